// File: rtl/idw_cfg.svh
// Offsets, field positions, reset values and fixed words of the identify block.
// Assumes APB byte addresses and 32-bit data, one register per aligned word.
`ifndef IDW_CFG_SVH
`define IDW_CFG_SVH
// ======================================================================
// Register map
`define IDW_WIN_BASE   12'h000
`define IDW_WIN_LAST   12'h07c
`define IDW_CYL_OFF    12'h080
`define IDW_HEAD_OFF   12'h084
`define IDW_SPT_OFF    12'h088
`define IDW_CAP_OFF    12'h08c
`define IDW_MULT_OFF   12'h090
`define IDW_NMLO_OFF   12'h094
`define IDW_NMHI_OFF   12'h098
`define IDW_CFG_OFF    12'h09c
`define IDW_CTRL_OFF   12'h0a0
`define IDW_STAT_OFF   12'h0a4
// ======================================================================
// Field positions of the configuration, control and multiple registers
`define IDW_CFG_DMA_LSB 0
`define IDW_CFG_QD_LSB  8
`define IDW_CFG_STD_BIT 16
`define IDW_CFG_MSB_BIT 17
`define IDW_CFG_SSP_BIT 18
`define IDW_CTRL_SNAP   0
`define IDW_MULT_VBIT   8
// ======================================================================
// Reset values and fixed words
`define IDW_CFG_RST    32'h0004_0000
`define IDW_W51_PIO    16'h0200
`define IDW_W52_DMA    16'h0200
`define IDW_W53_VALID  16'h0007
`define IDW_W63_SUPP   8'h07
`define IDW_W64_PIO    16'h0003
`define IDW_W65_MDMA   16'h0078
`define IDW_W66_MDMA   16'h0078
`define IDW_W67_PIO    16'h00f0
`define IDW_W68_PIO    16'h0078
`define IDW_W76_SATA   16'h0306
`define IDW_W78_SUPP   16'h005e
`define IDW_W49_IORDY  16'h0e00
`define IDW_W50_VALID  16'h4000
`define IDW_LBA28_MAX  48'h0000_0fff_ffff
`define IDW_TOT_SAT    32'h00ff_ffff
`endif

// File: rtl/idw_pkg.sv
// Types of the identify block: live settings and full register state.
// Assumes the constants header is compiled alongside.
package idw_pkg;
    // ==================================================================
    // Live settings as seen by the identify words
    typedef struct packed {
        logic [15:0] cyl;
        logic [15:0] heads;
        logic [15:0] spt;
        logic [31:0] cap;
        logic [8:0]  mult;
        logic [31:0] total;
        logic [7:0]  dma;
        logic [4:0]  qd;
        logic        std_enc;
        logic        min_sb;
        logic        ssp_en;
    } idw_live_t;

    // Whole state of the top module
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        wd_vld;
        logic [15:0] wd_data;
        logic [47:0] nmax;
        idw_live_t   live;
        idw_live_t   snap;
        logic        snap_vld;
        logic [7:0]  snap_cnt;
    } idw_state_t;
endpackage : idw_pkg

// File: rtl/idw_top.sv
// Identify data words 48 to 79: live settings, snapshot and word readout.
// Assumes an APB master on the register side and a sector engine that
// pulls words by index one at a time; all inputs synchronous to ref_clk.
//
// The register addresses and the APB register port are this design's own decisions.
`include "idw_cfg.svh"

// ======================================================================
module idw_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Identify command and word readout
    input  wire logic        id_req,
    input  wire logic        wd_rd,
    input  wire logic [4:0]  wd_idx,
    output logic             wd_vld,
    output logic [15:0]      wd_data,
    output logic             snap_vld
);
    // ==================================================================
    // Word assembly
    // Builds one word of the range from a snapshot; idx is word minus 48
    function automatic logic [15:0] idw_word(input logic [4:0] idx,
                                            input idw_pkg::idw_live_t s);
        logic [15:0] w;
        w = 16'h0000;
        unique case (idx)
            5'h01: w = `IDW_W49_IORDY | {2'b00, s.std_enc, 13'h0000};
            5'h02: w = `IDW_W50_VALID | {15'h0000, s.min_sb};
            5'h03: w = `IDW_W51_PIO;
            5'h04: w = `IDW_W52_DMA;
            5'h05: w = `IDW_W53_VALID;
            5'h06: w = s.cyl;
            5'h07: w = s.heads;
            5'h08: w = s.spt;
            5'h09: w = s.cap[15:0];
            5'h0a: w = s.cap[31:16];
            5'h0b: w = {7'h00, s.mult};
            5'h0c: w = s.total[15:0];
            5'h0d: w = s.total[31:16];
            5'h0f: w = {s.dma, `IDW_W63_SUPP};
            5'h10: w = `IDW_W64_PIO;
            5'h11: w = `IDW_W65_MDMA;
            5'h12: w = `IDW_W66_MDMA;
            5'h13: w = `IDW_W67_PIO;
            5'h14: w = `IDW_W68_PIO;
            5'h1b: w = {11'h000, s.qd};
            5'h1c: w = `IDW_W76_SATA;
            5'h1e: w = `IDW_W78_SUPP;
            5'h1f: w = {9'h000, s.ssp_en, 6'h00};
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : idw_word

    // Reports the native maximum, clipped when it passes 28-bit reach
    function automatic logic [31:0] idw_total(input logic [47:0] nmax);
        logic [31:0] t;
        t = nmax[31:0];
        if (nmax > `IDW_LBA28_MAX) begin
            t = `IDW_TOT_SAT;
        end
        return t;
    endfunction : idw_total

    // ==================================================================
    // State
    idw_pkg::idw_state_t st_q;
    idw_pkg::idw_state_t st_d;

    logic access;
    logic wr_take;
    logic take_snap;
    logic win_hit;
    logic map_hit;

    // Outputs come straight from flip-flops
    assign pready   = st_q.pready;
    assign pslverr  = st_q.pslverr;
    assign prdata   = st_q.prdata;
    assign wd_vld   = st_q.wd_vld;
    assign wd_data  = st_q.wd_data;
    assign snap_vld = st_q.snap_vld;

    // ==================================================================
    // Bus decode
    // Access phase gets one wait state so read data leaves a flip-flop
    assign access  = psel && penable && !st_q.pready;
    assign wr_take = psel && penable && st_q.pready && pwrite && !st_q.pslverr;
    assign win_hit = (paddr <= `IDW_WIN_LAST) && (paddr[1:0] == 2'b00);
    assign map_hit = win_hit ||
                     ((paddr[1:0] == 2'b00) && (paddr >= `IDW_CYL_OFF) &&
                      (paddr <= `IDW_STAT_OFF));
    // Snapshot on the identify command or a software request
    assign take_snap = id_req ||
                       (wr_take && (paddr == `IDW_CTRL_OFF) &&
                        pwdata[`IDW_CTRL_SNAP]);

    // ==================================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.pready = access;
        st_d.pslverr = 1'b0;
        st_d.live.total = idw_total(st_q.nmax);
        // Read data and error are fixed in the wait cycle
        if (access) begin
            st_d.prdata = 32'h0000_0000;
            if (!map_hit || (pwrite && win_hit)) begin
                st_d.pslverr = 1'b1;
            end else if (!pwrite) begin
                if (win_hit) begin
                    st_d.prdata = {16'h0000, idw_word(paddr[6:2], st_q.snap)};
                end else begin
                    unique case (paddr)
                        `IDW_CYL_OFF:  st_d.prdata = {16'h0000, st_q.live.cyl};
                        `IDW_HEAD_OFF: st_d.prdata = {16'h0000, st_q.live.heads};
                        `IDW_SPT_OFF:  st_d.prdata = {16'h0000, st_q.live.spt};
                        `IDW_CAP_OFF:  st_d.prdata = st_q.live.cap;
                        `IDW_MULT_OFF: st_d.prdata = {23'h000000, st_q.live.mult};
                        `IDW_NMLO_OFF: st_d.prdata = st_q.nmax[31:0];
                        `IDW_NMHI_OFF: st_d.prdata = {16'h0000, st_q.nmax[47:32]};
                        `IDW_CFG_OFF: begin
                            st_d.prdata[`IDW_CFG_DMA_LSB +: 8] = st_q.live.dma;
                            st_d.prdata[`IDW_CFG_QD_LSB +: 5]  = st_q.live.qd;
                            st_d.prdata[`IDW_CFG_STD_BIT]      = st_q.live.std_enc;
                            st_d.prdata[`IDW_CFG_MSB_BIT]      = st_q.live.min_sb;
                            st_d.prdata[`IDW_CFG_SSP_BIT]      = st_q.live.ssp_en;
                        end
                        `IDW_STAT_OFF: st_d.prdata = {16'h0000, st_q.snap_cnt,
                                                      7'h00, st_q.snap_vld};
                        default: st_d.prdata = 32'h0000_0000;
                    endcase
                end
            end
        end
        // Writes land only at the edge that completes the transfer
        if (wr_take) begin
            unique case (paddr)
                `IDW_CYL_OFF:  st_d.live.cyl = pwdata[15:0];
                `IDW_HEAD_OFF: st_d.live.heads = pwdata[15:0];
                `IDW_SPT_OFF:  st_d.live.spt = pwdata[15:0];
                `IDW_CAP_OFF:  st_d.live.cap = pwdata;
                `IDW_MULT_OFF: st_d.live.mult = pwdata[8:0];
                `IDW_NMLO_OFF: st_d.nmax[31:0] = pwdata;
                `IDW_NMHI_OFF: st_d.nmax[47:32] = pwdata[15:0];
                `IDW_CFG_OFF: begin
                    st_d.live.dma     = pwdata[`IDW_CFG_DMA_LSB +: 8];
                    st_d.live.qd      = pwdata[`IDW_CFG_QD_LSB +: 5];
                    st_d.live.std_enc = pwdata[`IDW_CFG_STD_BIT];
                    st_d.live.min_sb  = pwdata[`IDW_CFG_MSB_BIT];
                    st_d.live.ssp_en  = pwdata[`IDW_CFG_SSP_BIT];
                end
                default: st_d.live = st_d.live;
            endcase
        end
        // Snapshot freezes what is in force when the sector is built
        if (take_snap) begin
            st_d.snap = st_q.live;
            st_d.snap.total = idw_total(st_q.nmax);
            st_d.snap_vld = 1'b1;
            st_d.snap_cnt = 8'(st_q.snap_cnt + 8'h01);
        end
        // Sector engine reads one word per request, one cycle later
        st_d.wd_vld = wd_rd;
        if (wd_rd) begin
            st_d.wd_data = idw_word(wd_idx, st_q.snap);
        end
    end

    // ==================================================================
    // Registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.live.ssp_en <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ==================================================================
    // Checks
    pready_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pready |=> !pready)
        else $error("pready held more than one cycle");

    word49_bits_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h01 |->
        wd_data[11:10] == 2'b11 && wd_data[15:14] == 2'b00 &&
        wd_data[12] == 1'b0 && wd_data[9:0] == 10'h200 &&
        wd_data[13] == $past(st_q.snap.std_enc))
        else $error("word 49 wrong");

    word50_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h02 |-> wd_data[15:1] == 15'h2000)
        else $error("word 50 pattern wrong");

    word53_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h05 |-> wd_data == 16'h0007)
        else $error("word 53 wrong");

    word63_supp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h0f |->
        wd_data == {$past(st_q.snap.dma), 8'h07})
        else $error("word 63 wrong");

    word76_sata_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h1c |-> wd_data == 16'h0306)
        else $error("word 76 wrong");

    word78_supp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h1e |-> wd_data == 16'h005e)
        else $error("word 78 wrong");

    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && ($past(wd_idx) == 5'h00 || $past(wd_idx) == 5'h0e ||
                   $past(wd_idx) == 5'h1d) |-> wd_data == 16'h0000)
        else $error("reserved word not zero");

    total_sat_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        id_req && st_q.nmax > 48'h0000_0fff_ffff |=>
        st_q.snap.total == 32'h00ff_ffff)
        else $error("total not saturated");

    snap_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        id_req |=> snap_vld && st_q.snap.cyl == $past(st_q.live.cyl) &&
        st_q.snap.mult == $past(st_q.live.mult))
        else $error("snapshot missed live settings");

    // ==================================================================
    // Fixed words, and word 79 with its ssp_en bit; a stuck constant would reach every host unnoticed
    word51_pio_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h03 |-> wd_data == 16'h0200)
        else $error("word 51 wrong");

    word52_dma_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h04 |-> wd_data == 16'h0200)
        else $error("word 52 wrong");

    word64_pio_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h10 |-> wd_data == 16'h0003)
        else $error("word 64 wrong");

    mdma_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && ($past(wd_idx) == 5'h11 || $past(wd_idx) == 5'h12) |->
        wd_data == 16'h0078)
        else $error("words 65 and 66 wrong");

    word67_pio_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h13 |-> wd_data == 16'h00f0)
        else $error("word 67 wrong");

    word68_pio_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h14 |-> wd_data == 16'h0078)
        else $error("word 68 wrong");

    reserved_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) >= 5'h15 && $past(wd_idx) <= 5'h1a |->
        wd_data == 16'h0000)
        else $error("words 69 to 74 not zero");

    word79_en_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h1f |->
        wd_data == {9'h000, $past(st_q.snap.ssp_en), 6'h00})
        else $error("word 79 wrong");

    // ==================================================================
    // Live words; each must come from the snapshot, not the live copy
    cyl_word_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h06 |-> wd_data == $past(st_q.snap.cyl))
        else $error("word 54 wrong");

    cap_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h09 |-> wd_data == $past(st_q.snap.cap[15:0]))
        else $error("word 57 wrong");

    cap_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h0a |-> wd_data == $past(st_q.snap.cap[31:16]))
        else $error("word 58 wrong");

    word59_mult_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h0b |->
        wd_data == {7'h00, $past(st_q.snap.mult)})
        else $error("word 59 wrong");

    total_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h0c |-> wd_data == $past(st_q.snap.total[15:0]))
        else $error("word 60 wrong");

    total_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h0d |-> wd_data == $past(st_q.snap.total[31:16]))
        else $error("word 61 wrong");

    word50_standby_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h02 |-> wd_data[0] == $past(st_q.snap.min_sb))
        else $error("word 50 standby bit wrong");

    queue_depth_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_vld && $past(wd_idx) == 5'h1b |->
        wd_data == {11'h000, $past(st_q.snap.qd)})
        else $error("word 75 wrong");

    total_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        id_req && st_q.nmax <= 48'h0000_0fff_ffff |=>
        st_q.snap.total == $past(st_q.nmax[31:0]))
        else $error("total not passed through");

    // ==================================================================
    // Handshakes and snapshot status; the sector engine relies on a fixed one-cycle answer
    word_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wd_rd |=> wd_vld)
        else $error("word pull not answered");

    word_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wd_rd |=> !wd_vld)
        else $error("word valid without pull");

    apb_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        psel && penable && !pready |=> pready)
        else $error("access phase not answered");

    error_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pslverr |-> pready)
        else $error("error outside completion");

    snap_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take_snap |=> st_q.snap_cnt == 8'($past(st_q.snap_cnt) + 8'h01))
        else $error("snapshot count not advanced");

    snap_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        snap_vld |=> snap_vld)
        else $error("snapshot valid dropped");

endmodule : idw_top

// File: bench/idw_host_model.sv
// Host-side model: issues the identify command and pulls words by index.
// Assumes the identify block answers each word pull within a few cycles.
module idw_host_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Requests towards the block
    output logic             id_req,
    output logic             wd_rd,
    output logic [4:0]       wd_idx,
    // Returned word
    input  wire logic        wd_vld,
    input  wire logic [15:0] wd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // Idle levels at time zero
    initial begin
        id_req = 1'b0;
        wd_rd  = 1'b0;
        wd_idx = 5'h00;
    end

    // Identify command as a single-cycle pulse
    task snap;
        @(posedge ref_clk);
        id_req <= 1'b1;
        @(posedge ref_clk);
        id_req <= 1'b0;
    endtask : snap

    // Pull one word; the index is scrambled once taken so stale use shows
    task get(input logic [4:0] idx, output logic [15:0] d, output logic ok);
        int n;
        @(posedge ref_clk);
        wd_rd  <= 1'b1;
        wd_idx <= idx;
        @(posedge ref_clk);
        wd_rd  <= 1'b0;
        wd_idx <= ~idx;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wd_vld !== 1'b1 && n < 8);
        d  = wd_data;
        ok = (wd_vld === 1'b1);
    endtask : get
endmodule : idw_host_model

// File: bench/idw_top_bench.sv
// Bench of the identify word block: APB master, host model, word checks.
// Assumes the register map of the constants header and one clock.
`include "idw_cfg.svh"
module idw_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ==================================================================
    // Signals and live settings mirror
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        pready, pslverr, wd_vld, snap_vld, id_req, wd_rd;
    logic [31:0] prdata, rd;
    logic [15:0] wd_data, cyl, heads, spt;
    logic [4:0]  wd_idx, qd;
    logic [31:0] cap;
    logic [8:0]  mult;
    logic [47:0] nmax;
    logic [7:0]  dma;
    logic        std_e, msb, ssp, err;
    int          mismatches  = 0;
    int          checks_done = 0;

    always #5 ref_clk = ~ref_clk;

    idw_top idw_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .id_req(id_req), .wd_rd(wd_rd),
        .wd_idx(wd_idx), .wd_vld(wd_vld), .wd_data(wd_data), .snap_vld(snap_vld));
    idw_host_model idw_host_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .id_req(id_req),
        .wd_rd(wd_rd), .wd_idx(wd_idx), .wd_vld(wd_vld), .wd_data(wd_data));

    // ==================================================================
    // Verdict and comparison
    task results;
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // APB transfer; an edge passes first so no signal is assigned twice
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            results();
        end
    endtask : apb

    // Expected word from the mirror of the live settings
    function automatic logic [15:0] exp_word(input int w);
        logic [31:0] tot;
        tot = (nmax > 48'h0000_0fff_ffff) ? 32'h00ff_ffff : nmax[31:0];
        case (w)
            49: return {2'b00, std_e, 2'b01, 11'h600};
            50: return {15'h2000, msb};
            51, 52: return 16'h0200;
            53: return 16'h0007;
            54: return cyl;
            55: return heads;
            56: return spt;
            57: return cap[15:0];
            58: return cap[31:16];
            59: return {7'h00, mult};
            60: return tot[15:0];
            61: return tot[31:16];
            63: return {dma, 8'h07};
            64: return 16'h0003;
            65, 66, 68: return 16'h0078;
            67: return 16'h00f0;
            75: return {11'h000, qd};
            76: return 16'h0306;
            78: return 16'h005e;
            79: return {9'h000, ssp, 6'h00};
            default: return 16'h0000;
        endcase
    endfunction : exp_word

    // ==================================================================
    // Scenarios
    task t_reset;
        apb(1'b0, `IDW_CFG_OFF, 32'h0);
        chk(rd, 32'h0004_0000);
        apb(1'b0, `IDW_STAT_OFF, 32'h0);
        chk(rd, 32'h0000_0000);
        chk({31'h0, snap_vld}, 32'h0);
    endtask : t_reset

    // Program settings, take the identify snapshot, pull all 32 words
    task t_sector;
        logic [15:0] d;
        logic        ok;
        apb(1'b1, `IDW_CYL_OFF, {16'h0, cyl});
        apb(1'b1, `IDW_HEAD_OFF, {16'h0, heads});
        apb(1'b1, `IDW_SPT_OFF, {16'h0, spt});
        apb(1'b1, `IDW_CAP_OFF, cap);
        apb(1'b1, `IDW_MULT_OFF, {23'h0, mult});
        apb(1'b1, `IDW_NMLO_OFF, nmax[31:0]);
        apb(1'b1, `IDW_NMHI_OFF, {16'h0, nmax[47:32]});
        apb(1'b1, `IDW_CFG_OFF, {13'h0, ssp, msb, std_e, 3'h0, qd, dma});
        idw_host_model_i.snap();
        for (int w = 48; w < 80; w++) begin
            idw_host_model_i.get(5'(w - 48), d, ok);
            chk({31'h0, ok}, 32'h1);
            chk({16'h0, d}, {16'h0, exp_word(w)});
        end
        chk({31'h0, snap_vld}, 32'h1);
    endtask : t_sector

    // Settings changed without a new identify leave the sector unchanged
    task t_hold;
        logic [15:0] d;
        logic        ok;
        apb(1'b1, `IDW_CYL_OFF, {16'h0, ~cyl});
        idw_host_model_i.get(5'd6, d, ok);
        chk({16'h0, d}, {16'h0, cyl});
        apb(1'b0, 12'h018, 32'h0);
        chk({16'h0, rd[15:0]}, {16'h0, cyl});
        // Software snapshot request picks up the changed setting
        apb(1'b1, `IDW_CTRL_OFF, 32'h0000_0001);
        idw_host_model_i.get(5'd6, d, ok);
        chk({16'h0, d}, {16'h0, ~cyl});
        apb(1'b0, `IDW_STAT_OFF, 32'h0);
        chk(rd, 32'h0000_0201);
    endtask : t_hold

    // Writes to the window and stray addresses are refused
    task t_refuse;
        apb(1'b1, `IDW_WIN_BASE, 32'h0000_ffff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, `IDW_WIN_BASE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h082, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_refuse

    // Reset in mid-run restores the defaults and clears the snapshot
    task t_rerun;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h0000_0000);
    endtask : t_rerun

    // ==================================================================
    // Main sequence; the first set sits on the saturation boundary
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        {cyl, heads, spt, cap} = {16'h3fff, 16'h0010, 16'h003f, 32'h00fb_fc10};
        {mult, nmax, dma, qd} = {9'h110, 48'h0000_0fff_ffff, 8'h04, 5'h1f};
        {std_e, msb, ssp} = 3'b111;
        t_sector();
        t_hold();
        {cyl, heads, spt, cap} = {16'h0000, 16'h000f, 16'h0001, 32'hffff_0001};
        {mult, nmax, dma, qd} = {9'h010, 48'h0000_1000_0000, 8'h02, 5'h00};
        {std_e, msb, ssp} = 3'b000;
        t_sector();
        t_refuse();
        t_rerun();
        results();
    end
endmodule : idw_top_bench
